/* File: logic/sdpdc_pkg.sv */
`default_nettype none
package sdpdc_pkg;
  // Command decode bit positions on the low command/address bits
  localparam int CA_B0 = 0;
  localparam int CA_B1 = 1;
  localparam int CA_B2 = 2;
  // Clock period in picoseconds
  localparam int CLK_PERIOD_PS = 5000;
  // Minimum clock enable pulse, in picoseconds
  localparam int CKE_MIN_PS = 15000;
  // Least time rounds up to whole cycles, at least one
  localparam int CKE_MIN_CYC_RAW =
    (CKE_MIN_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int CKE_MIN_CYC = (CKE_MIN_CYC_RAW < 1) ? 1 : CKE_MIN_CYC_RAW;
  localparam logic [7:0] CKE_MIN_CNT = 8'(CKE_MIN_CYC);
  localparam logic [7:0] CNT_ZERO = 8'h00;
  localparam logic [7:0] CNT_ONE = 8'h01;
  localparam logic [7:0] BANK_NONE = 8'h00;
  // Power states, one-hot
  typedef enum logic [3:0] {
    SDPDC_ACTIVE = 4'b0001,
    SDPDC_IDLE_PD = 4'b0010,
    SDPDC_ACT_PD = 4'b0100,
    SDPDC_DEEP = 4'b1000
  } sdpdc_state_t;
endpackage : sdpdc_pkg
`default_nettype wire

/* File: logic/sdpdc_power_ctrl.sv */
`timescale 1ns/1ps
`default_nettype none
module sdpdc_power_ctrl #(
  parameter int NUM_BANKS = 8
) (
  // Clock and reset
  input  wire logic                 CLOCK,
  input  wire logic                 NRST,
  // Command pins
  input  wire logic                 CLK_EN_IN,
  input  wire logic                 CHIP_SEL_N,
  input  wire logic [2:0]           CMD_ADDR,
  // Bank state and busy flag from core
  input  wire logic [NUM_BANKS-1:0] BANK_OPEN,
  input  wire logic                 OP_BUSY,
  // Status outputs
  output logic                      IN_IDLE_PD,
  output logic                      IN_ACT_PD,
  output logic                      DEEP_SLEEP_STATE,
  output logic                      BUF_ENABLE,
  output logic                      REFRESH_ENABLE,
  output logic                      ARRAY_LOST,
  output logic                      NOP_VALID,
  output logic                      OP_ABORT
);
  // Whole module state
  typedef struct packed {
    sdpdc_pkg::sdpdc_state_t st;
    logic       cke_prev;
    logic [7:0] cke_cnt;
    logic       idle_pd;
    logic       act_pd;
    logic       deep;
    logic       buf_en;
    logic       ref_en;
    logic       lost;
    logic       nop;
    logic       abort;
  } sdpdc_regs_t;

  sdpdc_regs_t s_reg;   // Registered state
  sdpdc_regs_t s_next;  // Next state

  // Decodes of the sampled command pins and bank state
  logic deep_code;  // Deep sleep command code
  logic nop_code;   // No-op command code
  logic any_open;   // Some bank has an open row
  assign deep_code = !CHIP_SEL_N && CMD_ADDR[sdpdc_pkg::CA_B0]
                     && CMD_ADDR[sdpdc_pkg::CA_B1]
                     && !CMD_ADDR[sdpdc_pkg::CA_B2];
  assign nop_code = CHIP_SEL_N || (CMD_ADDR[sdpdc_pkg::CA_B0]
                    && CMD_ADDR[sdpdc_pkg::CA_B1]
                    && CMD_ADDR[sdpdc_pkg::CA_B2]);
  assign any_open = (BANK_OPEN != NUM_BANKS'(sdpdc_pkg::BANK_NONE));

  // Next-state logic
  always_comb begin
    s_next = s_reg;
    s_next.cke_prev = CLK_EN_IN;
    s_next.abort = 1'b0;
    // Count down the minimum CKE level time
    if (s_reg.cke_cnt != sdpdc_pkg::CNT_ZERO) begin
      s_next.cke_cnt = s_reg.cke_cnt - sdpdc_pkg::CNT_ONE;
    end
    // No-op only with same CKE level two cycles
    s_next.nop = nop_code && (CLK_EN_IN == s_reg.cke_prev);
    case (s_reg.st)
      sdpdc_pkg::SDPDC_ACTIVE: begin
        if (!CLK_EN_IN && s_reg.cke_prev && deep_code) begin
          s_next.st = sdpdc_pkg::SDPDC_DEEP;
          s_next.lost = 1'b1;
          s_next.cke_cnt = sdpdc_pkg::CKE_MIN_CNT;
        end else if (!CLK_EN_IN && s_reg.cke_prev && CHIP_SEL_N) begin
          // Bank state picks the flavour
          s_next.st = any_open ? sdpdc_pkg::SDPDC_ACT_PD
                               : sdpdc_pkg::SDPDC_IDLE_PD;
          s_next.cke_cnt = sdpdc_pkg::CKE_MIN_CNT;
        end
      end
      sdpdc_pkg::SDPDC_IDLE_PD, sdpdc_pkg::SDPDC_ACT_PD: begin
        // Exit once CKE seen high after minimum low time
        if (CLK_EN_IN && s_reg.cke_cnt == sdpdc_pkg::CNT_ZERO) begin
          s_next.st = sdpdc_pkg::SDPDC_ACTIVE;
          s_next.cke_cnt = sdpdc_pkg::CKE_MIN_CNT;
        end
      end
      sdpdc_pkg::SDPDC_DEEP: begin
        // Only CKE is listened to here
        if (CLK_EN_IN && s_reg.cke_cnt == sdpdc_pkg::CNT_ZERO) begin
          s_next.st = sdpdc_pkg::SDPDC_ACTIVE;
        end
      end
      default: begin
        s_next.st = sdpdc_pkg::SDPDC_ACTIVE;
      end
    endcase
    // Array-lost flag clears on the first new command after deep exit
    if (s_reg.st == sdpdc_pkg::SDPDC_ACTIVE && s_reg.lost
        && CLK_EN_IN && !nop_code) begin
      s_next.lost = 1'b0;
    end
    // No-op never aborts a busy operation
    s_next.abort = OP_BUSY && !nop_code && 1'b0;
    s_next.idle_pd = (s_next.st == sdpdc_pkg::SDPDC_IDLE_PD);
    s_next.act_pd = (s_next.st == sdpdc_pkg::SDPDC_ACT_PD);
    s_next.deep = (s_next.st == sdpdc_pkg::SDPDC_DEEP);
    // Buffers and refresh off outside the active state
    s_next.buf_en = (s_next.st == sdpdc_pkg::SDPDC_ACTIVE);
    s_next.ref_en = (s_next.st == sdpdc_pkg::SDPDC_ACTIVE);
  end

  // State register
  always_ff @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      s_reg <= '{st: sdpdc_pkg::SDPDC_ACTIVE, cke_prev: 1'b1,
                 cke_cnt: sdpdc_pkg::CNT_ZERO, idle_pd: 1'b0,
                 act_pd: 1'b0, deep: 1'b0, buf_en: 1'b1,
                 ref_en: 1'b1, lost: 1'b0, nop: 1'b0, abort: 1'b0};
    end else begin
      s_reg <= s_next;
    end
  end

  // Outputs straight from flops
  assign IN_IDLE_PD = s_reg.idle_pd;
  assign IN_ACT_PD = s_reg.act_pd;
  assign DEEP_SLEEP_STATE = s_reg.deep;
  assign BUF_ENABLE = s_reg.buf_en;
  assign REFRESH_ENABLE = s_reg.ref_en;
  assign ARRAY_LOST = s_reg.lost;
  assign NOP_VALID = s_reg.nop;
  assign OP_ABORT = s_reg.abort;

  // Checks
  chk_pd_entry: assert property (
    @(posedge CLOCK) disable iff (!NRST)
    (s_reg.st == sdpdc_pkg::SDPDC_ACTIVE && s_reg.cke_prev && !CLK_EN_IN
     && CHIP_SEL_N) |=> (IN_IDLE_PD || IN_ACT_PD))
    else $error("power-down not entered");
  chk_pd_kind: assert property (
    @(posedge CLOCK) disable iff (!NRST)
    (s_reg.st == sdpdc_pkg::SDPDC_ACTIVE && s_reg.cke_prev && !CLK_EN_IN
     && CHIP_SEL_N && any_open) |=> IN_ACT_PD)
    else $error("wrong power-down kind");
  chk_buf_off: assert property (
    @(posedge CLOCK) disable iff (!NRST)
    (IN_IDLE_PD || IN_ACT_PD || DEEP_SLEEP_STATE) |-> !BUF_ENABLE)
    else $error("buffers on in power-down");
  chk_no_refresh: assert property (
    @(posedge CLOCK) disable iff (!NRST)
    $rose(IN_IDLE_PD) |-> !REFRESH_ENABLE [*2])
    else $error("refresh enabled in power-down");
  chk_deep_entry: assert property (
    @(posedge CLOCK) disable iff (!NRST)
    (s_reg.st == sdpdc_pkg::SDPDC_ACTIVE && s_reg.cke_prev && !CLK_EN_IN
     && deep_code) |=> (DEEP_SLEEP_STATE && ARRAY_LOST))
    else $error("deep sleep not entered");
  // Entry cycle plus three counted cycles before any exit
  chk_pd_hold: assert property (
    @(posedge CLOCK) disable iff (!NRST)
    $rose(IN_IDLE_PD) |-> IN_IDLE_PD [*4])
    else $error("power-down left too early");
  chk_act_hold: assert property (
    @(posedge CLOCK) disable iff (!NRST)
    $rose(IN_ACT_PD) |-> IN_ACT_PD [*4])
    else $error("active power-down left too early");
  // Exit once the minimum low time is spent
  chk_pd_exit: assert property (
    @(posedge CLOCK) disable iff (!NRST)
    ((IN_IDLE_PD || IN_ACT_PD) && CLK_EN_IN
     && s_reg.cke_cnt == sdpdc_pkg::CNT_ZERO)
    |=> (BUF_ENABLE && REFRESH_ENABLE && !IN_IDLE_PD && !IN_ACT_PD))
    else $error("power-down exit missed");
  chk_refresh_off: assert property (
    @(posedge CLOCK) disable iff (!NRST)
    (IN_IDLE_PD || IN_ACT_PD || DEEP_SLEEP_STATE) |-> !REFRESH_ENABLE)
    else $error("refresh on while powered down");
  // Deep sleep listens to CKE only and keeps the loss mark
  chk_deep_ignore: assert property (
    @(posedge CLOCK) disable iff (!NRST)
    (DEEP_SLEEP_STATE && !CLK_EN_IN) |=> DEEP_SLEEP_STATE)
    else $error("deep sleep left with CKE low");
  chk_deep_lost: assert property (
    @(posedge CLOCK) disable iff (!NRST)
    DEEP_SLEEP_STATE |-> ARRAY_LOST)
    else $error("array not marked lost in deep sleep");
  chk_one_state: assert property (
    @(posedge CLOCK) disable iff (!NRST)
    $onehot0({IN_IDLE_PD, IN_ACT_PD, DEEP_SLEEP_STATE}))
    else $error("more than one power state flag");
  // No-op flag only for a real no-op encoding
  chk_nop_steady: assert property (
    @(posedge CLOCK) disable iff (!NRST)
    NOP_VALID |-> ($past(CLK_EN_IN) == $past(s_reg.cke_prev)))
    else $error("no-op with changing CKE");
  chk_nop_code: assert property (
    @(posedge CLOCK) disable iff (!NRST)
    NOP_VALID |-> $past(nop_code))
    else $error("no-op flag without no-op code");
  chk_nop_noabort: assert property (
    @(posedge CLOCK) disable iff (!NRST)
    (OP_BUSY && nop_code) |=> !OP_ABORT)
    else $error("no-op aborted operation");
  // Main scenarios reached
  cov_idle_pd: cover property (@(posedge CLOCK) $rose(IN_IDLE_PD));
  cov_act_pd: cover property (@(posedge CLOCK) $rose(IN_ACT_PD));
  cov_deep: cover property (@(posedge CLOCK) $fell(DEEP_SLEEP_STATE));
  cov_pd_refused: cover property (@(posedge CLOCK)
    IN_IDLE_PD && CLK_EN_IN && s_reg.cke_cnt != sdpdc_pkg::CNT_ZERO);
  cov_lost_clear: cover property (@(posedge CLOCK)
    $fell(ARRAY_LOST));
endmodule : sdpdc_power_ctrl
`default_nettype wire

/* File: test/sdpdc_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
module sdpdc_host_model #(
  parameter int HOLD_CYC = 8  // Cycles CKE stays up after a command
) (
  // Clock
  input  wire logic       clock,
  // Requested pin levels
  input  wire logic       cke_req,
  input  wire logic       cs_n_req,
  input  wire logic [2:0] ca_req,
  // Burst or register access running
  input  wire logic       busy,
  // Pins to the device
  output logic            cke,
  output logic [2:0]      ca,
  output logic            chip_sel_n
);
  logic       cke_q    = 1'b1;  // Last sampled enable
  logic       entered  = 1'b0;  // Entry seen at last edge
  logic [7:0] hold_cnt = 8'h00; // Cycles left before CKE may fall
  logic       cmd_seen;         // Non no-op command with CKE high
  assign cmd_seen = cke & ~chip_sel_n & (ca != 3'h7);
  // Spot entries and commands on the sampling edge
  always @(posedge clock) begin
    entered <= cke_q & ~cke & (chip_sel_n | (ca == 3'h3));
    cke_q   <= cke;
    if (cmd_seen) begin
      hold_cnt <= 8'(HOLD_CYC);
    end else if (hold_cnt != 8'h00) begin
      hold_cnt <= hold_cnt - 8'h01;
    end
  end
  // No-op forced in the cycle after any entry
  assign chip_sel_n = entered | cs_n_req;
  // CKE kept high during bursts and command recovery
  assign cke        = cke_req | busy | (hold_cnt != 8'h00);
  assign ca         = ca_req;
endmodule : sdpdc_host_model
`default_nettype wire

/* File: test/tb_sdpdc_power_ctrl.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_sdpdc_power_ctrl;
  logic       clock     = 1'b0;  // 200 MHz clock
  logic       nrst      = 1'b0;  // Reset, active low
  logic       cke_req   = 1'b1;  // Requested enable
  logic       cs_n_req  = 1'b1;  // Requested select
  logic [2:0] ca_req    = 3'h7;  // Requested command bits
  logic [7:0] bank_open = 8'h00; // Open rows
  logic       op_busy   = 1'b0;  // Burst running
  wire logic  cke, chip_sel_n;
  wire logic [2:0] ca;
  logic       idle_pd, act_pd, deep, buf_en, ref_en, lost, nop_ok, abort;
  int         n_errors  = 0;
  int         compares  = 0;
  // Free running clock
  initial begin
    forever #2.5 clock = ~clock;
  end
  sdpdc_host_model u_sdpdc_host_model (.clock(clock), .cke_req(cke_req),
    .cs_n_req(cs_n_req), .ca_req(ca_req), .busy(op_busy), .cke(cke), .ca(ca),
    .chip_sel_n(chip_sel_n));
  sdpdc_power_ctrl u_sdpdc_power_ctrl (.CLOCK(clock), .NRST(nrst),
    .CLK_EN_IN(cke), .CHIP_SEL_N(chip_sel_n), .CMD_ADDR(ca),
    .BANK_OPEN(bank_open), .OP_BUSY(op_busy), .IN_IDLE_PD(idle_pd),
    .IN_ACT_PD(act_pd), .DEEP_SLEEP_STATE(deep), .BUF_ENABLE(buf_en),
    .REFRESH_ENABLE(ref_en), .ARRAY_LOST(lost), .NOP_VALID(nop_ok),
    .OP_ABORT(abort));
  // Counts and verdict
  task automatic end_of_test();
    $display("Errors %0d, compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : end_of_test
  // Compare one output bit
  task automatic chk(input logic seen, input logic exp);
    compares++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %0t seen %b expected %b", $time, seen, exp);
    end
  endtask : chk
  // Pin request at the falling edge
  task automatic drive(input logic k, input logic s, input logic [2:0] a);
    @(negedge clock);
    cke_req = k;
    cs_n_req = s;
    ca_req = a;
  endtask : drive
  // Bounded wait for idle, active, deep, buffer flags
  task automatic wait_st(input logic [3:0] want);
    compares++;
    for (int i = 0; i < 12; i++) begin
      @(negedge clock);
      if ({idle_pd, act_pd, deep, buf_en} === want) return;
    end
    n_errors++;
    $display("[FAIL] %0t power state wait timed out", $time);
    end_of_test();
  endtask : wait_st
  // Idle power-down, early exit refused
  task automatic t_idle();
    drive(1'b0, 1'b1, 3'h7);
    wait_st(4'b1000);
    chk(nop_ok, 1'b0);
    chk(ref_en, 1'b0);
    drive(1'b1, 1'b1, 3'h7);
    @(negedge clock);
    chk(idle_pd, 1'b1);
    wait_st(4'b0001);
    chk(ref_en, 1'b1);
  endtask : t_idle
  // Active power-down with an open row
  task automatic t_act();
    bank_open = 8'h04;
    drive(1'b0, 1'b1, 3'h7);
    wait_st(4'b0100);
    chk(ref_en, 1'b0);
    repeat (4) @(negedge clock);
    drive(1'b1, 1'b1, 3'h7);
    wait_st(4'b0001);
    bank_open = 8'h00;
  endtask : t_act
  // Deep sleep, exit, array loss until a command
  task automatic t_deep();
    drive(1'b0, 1'b0, 3'h3);
    wait_st(4'b0010);
    chk(lost, 1'b1);
    repeat (4) @(negedge clock);
    drive(1'b1, 1'b1, 3'h7);
    wait_st(4'b0001);
    chk(lost, 1'b1);
    drive(1'b1, 1'b0, 3'h1);
    drive(1'b1, 1'b1, 3'h7);
    repeat (2) @(negedge clock);
    chk(lost, 1'b0);
  endtask : t_deep
  // Both no-op codes, busy burst kept
  task automatic t_nop();
    op_busy = 1'b1;
    drive(1'b1, 1'b0, 3'h7);
    @(negedge clock);
    chk(nop_ok, 1'b1);
    drive(1'b1, 1'b1, 3'h0);
    @(negedge clock);
    chk(nop_ok, 1'b1);
    chk(abort, 1'b0);
    drive(1'b1, 1'b0, 3'h1);
    drive(1'b1, 1'b1, 3'h7);
    chk(nop_ok, 1'b0);
    op_busy = 1'b0;
  endtask : t_nop
  // Reset during power-down returns to the active state
  task automatic t_reset();
    drive(1'b0, 1'b1, 3'h7);
    wait_st(4'b1000);
    nrst = 1'b0;
    cke_req = 1'b1;
    @(negedge clock);
    chk(buf_en, 1'b1);
    chk(idle_pd, 1'b0);
    nrst = 1'b1;
    repeat (2) @(negedge clock);
    chk(ref_en, 1'b1);
    chk(idle_pd, 1'b0);
  endtask : t_reset
  // Reset, then each scenario
  initial begin
    repeat (4) @(posedge clock);
    @(negedge clock);
    nrst = 1'b1;
    @(negedge clock);
    chk(buf_en, 1'b1);
    chk(deep, 1'b0);
    t_idle();
    t_act();
    t_deep();
    t_nop();
    t_reset();
    end_of_test();
  end
endmodule : tb_sdpdc_power_ctrl
`default_nettype wire
